/* design/tap_consts.vh */
// Constants of the touch converter serial port
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
`define TAP_RESULT_BITS  12
`define TAP_CTRL_BITS    7
`define TAP_WORD_BITS    19
`define TAP_FIFO_DEPTH   32
`define TAP_FIFO_AW      5
`define TAP_TRACK_FALL   4'h5
`define TAP_ACQ_CYCLES   4'h3
`define TAP_HOLD_FALL    (`TAP_TRACK_FALL + `TAP_ACQ_CYCLES)
`define TAP_MSB_INDEX    4'hb
`define TAP_TRIAL_MID    12'h800
`endif

/* design/tap_fifo.v */
// Result FIFO with registered output stage
module tap_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst_b,
  // Fill side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  // Drain side
  output reg              out_valid,
  output reg  [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  wire [AW:0]     fill;

  // Output stage counts as a slot, so DEPTH words in all
  assign fill     = count + {{AW{1'b0}}, out_valid};
  assign in_ready = (fill != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  assign pop      = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  always @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr    <= rd_ptr + 1'b1;
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* design/tap_serial_port.v */
// Serial control and result port of the touch converter
`include "tap_consts.vh"
module tap_serial_port (
  // System
  input  wire        clock,
  input  wire        rst_b,
  // Serial pins, sampled on clock
  input  wire        cs_n,
  input  wire        serial_conversion_clock,
  input  wire        din,
  output reg         dout,
  output reg         dout_oe_n,
  output reg         busy,
  output reg         busy_oe_n,
  output reg         pen_touch_irq_n,
  output reg         pen_touch_irq_n_oe_n,
  // Analog front end
  input  wire        pen_touched,
  input  wire        cmp_above,
  output reg         track,
  output reg  [11:0] dac_code,
  // Result stream
  output wire        res_valid,
  output wire [18:0] res_data,
  input  wire        res_ready
);
  localparam ST_IDLE = 4'h1;
  localparam ST_CMD  = 4'h2;
  localparam ST_CONV = 4'h4;
  localparam ST_TAIL = 4'h8;

  reg  [3:0]                  state;
  reg                         sclk_q;
  reg  [3:0]                  fall_cnt;
  reg  [3:0]                  bit_idx;
  reg  [`TAP_CTRL_BITS-1:0]   ctrl;
  reg  [`TAP_RESULT_BITS-1:0] result;
  reg                         push;
  wire                        fifo_ready;
  wire                        sclk_rise;
  wire                        sclk_fall;
  wire [11:0]                 bit_mask;
  wire [11:0]                 next_code;

  // Serial clock is only an event source; one system clock runs everything
  assign sclk_rise = serial_conversion_clock && !sclk_q;
  assign sclk_fall = !serial_conversion_clock && sclk_q;
  assign bit_mask  = 12'h001 << bit_idx;
  // Keep decided bit, try next lower one: straight binary SAR
  assign next_code = (cmp_above ? dac_code : (dac_code & ~bit_mask)) | (bit_mask >> 1);

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      sclk_q               <= 1'b0;
      pen_touch_irq_n      <= 1'b0;
      pen_touch_irq_n_oe_n <= 1'b1;
    end
    else
    begin
      sclk_q               <= serial_conversion_clock;
      // Only ever pulls low; pull-up gives the high level
      pen_touch_irq_n      <= 1'b0;
      pen_touch_irq_n_oe_n <= !pen_touched;
    end
  end

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      state     <= ST_IDLE;
      fall_cnt  <= 4'h0;
      bit_idx   <= 4'h0;
      ctrl      <= {`TAP_CTRL_BITS{1'b0}};
      result    <= {`TAP_RESULT_BITS{1'b0}};
      push      <= 1'b0;
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
      busy      <= 1'b0;
      busy_oe_n <= 1'b1;
      track     <= 1'b0;
      dac_code  <= 12'h000;
    end
    else if (cs_n)
    begin
      // Deselected: dout and busy float and any frame in flight is dropped
      state     <= ST_IDLE;
      push      <= 1'b0;
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
      busy      <= 1'b0;
      busy_oe_n <= 1'b1;
      track     <= 1'b0;
    end
    else
    begin
      dout_oe_n <= 1'b0;
      busy_oe_n <= 1'b0;
      push      <= 1'b0;
      case (state)
        ST_IDLE, ST_TAIL:
        begin
          if (sclk_fall)
          begin
            dout <= 1'b0;
          end
          // A start bit is refused while the result FIFO is full
          if (sclk_rise && din && fifo_ready)
          begin
            state    <= ST_CMD;
            fall_cnt <= 4'h0;
            ctrl     <= {`TAP_CTRL_BITS{1'b0}};
          end
        end
        ST_CMD:
        begin
          if (sclk_rise)
          begin
            ctrl <= {ctrl[`TAP_CTRL_BITS-2:0], din};
          end
          if (sclk_fall)
          begin
            fall_cnt <= fall_cnt + 4'h1;
            if (fall_cnt + 4'h1 == `TAP_TRACK_FALL)
            begin
              track <= 1'b1;
            end
            if (fall_cnt + 4'h1 == `TAP_HOLD_FALL)
            begin
              track    <= 1'b0;
              busy     <= 1'b1;
              dac_code <= `TAP_TRIAL_MID;
              bit_idx  <= `TAP_MSB_INDEX;
              state    <= ST_CONV;
            end
          end
        end
        ST_CONV:
        begin
          if (sclk_fall)
          begin
            busy            <= 1'b0;
            dout            <= cmp_above;
            result[bit_idx] <= cmp_above;
            dac_code        <= next_code;
            if (bit_idx == 4'h0)
            begin
              push  <= 1'b1;
              state <= ST_TAIL;
            end
            else
            begin
              bit_idx <= bit_idx - 4'h1;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  tap_fifo #(
    .WIDTH (`TAP_WORD_BITS),
    .DEPTH (`TAP_FIFO_DEPTH),
    .AW    (`TAP_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_data   ({ctrl, result}),
    .in_ready  (fifo_ready),
    .out_valid (res_valid),
    .out_data  (res_data),
    .out_ready (res_ready)
  );
endmodule

/* tb/tap_chk.sv */
// Checker for the touch converter serial port
module tap_chk (
  input logic        clock, rst_b, cs_n, serial_conversion_clock, pen_touched, res_ready,
  input logic        dout, dout_oe_n, busy, busy_oe_n, pen_touch_irq_n, pen_touch_irq_n_oe_n,
  input logic        track, res_valid,
  input logic [11:0] dac_code,
  input logic [18:0] res_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sc_q;
  // Serial clock fall as the port detects it
  wire  fall = sc_q & ~serial_conversion_clock;
  always @(posedge clock)
    sc_q <= serial_conversion_clock;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_do; cs_n |=> dout_oe_n; endproperty
  a_do: assert property (p_do) else $error("dout driven idle");
  property p_bo; cs_n |=> busy_oe_n; endproperty
  a_bo: assert property (p_bo) else $error("busy driven idle");
  property p_on; !cs_n |=> !busy_oe_n && !dout_oe_n; endproperty
  a_on: assert property (p_on) else $error("outputs not driven");
  property p_ir; 1 |=> !pen_touch_irq_n && pen_touch_irq_n_oe_n == !$past(pen_touched); endproperty
  a_ir: assert property (p_ir) else $error("pen irq");
  property p_df; !cs_n && !$past(cs_n) && $changed(dout) |-> $past(fall) || $past(fall, 2); endproperty
  a_df: assert property (p_df) else $error("dout off fall");
  property p_tk; $rose(track) |-> $past(fall) || $past(fall, 2); endproperty
  a_tk: assert property (p_tk) else $error("track off fall");
  property p_hd; $fell(track) |-> busy && dac_code == 12'h800; endproperty
  a_hd: assert property (p_hd) else $error("hold start");
  property p_id; cs_n [*2] |-> !track; endproperty
  a_id: assert property (p_id) else $error("idle tracking");
  c_busy: cover property ($rose(busy));
  c_sel: cover property ($fell(cs_n));
  c_stall: cover property (res_valid && !res_ready);
endmodule

bind tap_serial_port tap_chk u_chk (.*);

/* tb/tap_host.sv */
// Host controller model on the serial pins
module tap_host (
  input  logic clock,
  input  logic dout,
  output logic cs_n = 1'b1,
  output logic serial_conversion_clock = 1'b0,
  output logic din = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int          falls = 0;
  logic [23:0] got;
  task automatic half(input logic v);
    serial_conversion_clock = v;
    falls += !v;
    repeat (2) @(negedge clock);
  endtask
  // Start bit, control bits, then clocks for result and trailing zeros
  task automatic frame(input logic [6:0] ctrl, input logic sel);
    cs_n = !sel;
    falls = 0;
    @(negedge clock);
    for (int k = 0; k < 24; k++)
    begin
      din = (k == 0) ? 1'b1 : (k < 8 ? ctrl[7-k] : 1'b0);
      got = {got[22:0], dout};
      half(1'b1);
      half(1'b0);
    end
    cs_n = 1'b1;
    din = ~din;
  endtask
endmodule

/* tb/tb_top.sv */
// Testbench of the touch converter serial port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, rst_b = 0, pen_touched = 0, res_ready = 0;
  logic [11:0] vin = 0;
  wire         cs_n, serial_conversion_clock, din, dout, dout_oe_n, busy, busy_oe_n, track, res_valid;
  wire         pen_touch_irq_n, pen_touch_irq_n_oe_n;
  wire  [11:0] dac_code;
  wire  [18:0] res_data;
  int          error_cnt = 0, n_checks = 0;
  // Ideal comparator in place of the analog input
  wire         cmp_above = (vin >= dac_code);
  always #50 clock = ~clock;
  tap_serial_port dut (.*);
  tap_host host (.clock, .dout(dout_oe_n ? 1'bz : dout), .cs_n, .serial_conversion_clock, .din);
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge track) chk(host.falls == 5, "track start");
  always @(negedge track) if (rst_b) chk(host.falls == 8, "track length");
  task automatic t_conv(input logic [11:0] v, input logic [6:0] c);
    vin = v;
    host.frame(c, 1'b1);
    chk(host.got[14:0] === {v, 3'h0}, "serial result");
    repeat (4) @(negedge clock);
    chk(res_valid === 1'b1 && res_data === {c, v}, "word");
    res_ready = 1;
    @(negedge clock);
    res_ready = 0;
  endtask
  task automatic t_idle;
    host.frame(7'h55, 1'b0);
    chk(dout_oe_n === 1'b1 && busy_oe_n === 1'b1 && res_valid === 1'b0, "idle");
  endtask
  task automatic t_pen;
    pen_touched = 1;
    repeat (2) @(negedge clock);
    chk(pen_touch_irq_n === 1'b0 && pen_touch_irq_n_oe_n === 1'b0, "pen down");
    pen_touched = 0;
    repeat (2) @(negedge clock);
    chk(pen_touch_irq_n_oe_n === 1'b1, "pen up");
  endtask
  // The last frame finds the buffer full and must be dropped
  task automatic t_fill;
    for (int i = 0; i < 33; i++)
    begin
      vin = 12'(i);
      host.frame(7'(i), 1'b1);
    end
    for (int i = 0; i < 32; i++)
    begin
      chk(res_valid === 1'b1 && res_data === {7'(i), 12'(i)}, "drain");
      res_ready = 1;
      @(negedge clock);
      res_ready = 0;
      @(negedge clock);
    end
    chk(res_valid === 1'b0, "full refused");
  endtask
  initial
  begin
    repeat (16) @(negedge clock);
    rst_b = 1;
    @(negedge clock);
    t_idle;
    t_pen;
    t_conv(12'h000, 7'h7f);
    t_conv(12'hfff, 7'h00);
    t_conv(12'ha5c, 7'h2b);
    t_fill;
    finish_test;
  end
  initial
  begin
    #1ms;
    chk(1'b0, "timeout");
    finish_test;
  end
endmodule
